/* File: hw/ssr_pkg.sv */
// Shared constants for the synchronous slave serial receiver
package ssr_pkg;

    // ========================================================
    // Register map (byte addresses, one aligned word each)
    localparam logic [7:0] OFF_RX_DATA   = 8'h00;
    localparam logic [7:0] OFF_RX_STAT   = 8'h04;
    localparam logic [7:0] OFF_TX_STAT   = 8'h08;
    localparam logic [7:0] OFF_BAUD      = 8'h0C;
    localparam logic [7:0] OFF_INT_STAT  = 8'h10;
    localparam logic [7:0] OFF_INT_MASK  = 8'h14;

    // ========================================================
    // Receive status and control fields
    localparam int RS_PORT_EN    = 7;
    localparam int RS_NINE_BIT   = 6;
    localparam int RS_SINGLE_RX  = 5;
    localparam int RS_CONT_RX    = 4;
    localparam int RS_ADDR_DET   = 3;
    localparam int RS_FRAME_ERR  = 2;
    localparam int RS_OVERRUN    = 1;
    localparam int RS_NINTH_BIT  = 0;

    // Transmit status and control fields that steer reception
    localparam int TS_CLK_MASTER = 7;
    localparam int TS_SYNC_MODE  = 4;

    // Baud control fields
    localparam int BC_RX_IDLE    = 6;
    localparam int BC_CLK_POL    = 4;

    // Interrupt status and mask fields
    localparam int IS_RX_DONE    = 0;
    localparam int IS_OVERRUN    = 1;
    localparam int IS_WIDTH      = 2;

    // ========================================================
    // Reset values
    localparam logic [7:0] RST_RX_CTL   = 8'h00;
    localparam logic [7:0] RST_TX_CTL   = 8'h00;
    localparam logic [7:0] RST_BAUD     = 8'h00;
    localparam logic [1:0] RST_INT      = 2'h0;

    // ========================================================
    // Character store
    localparam int          WORD_W      = 9;
    localparam int          FIFO_DEPTH  = 2;
    localparam int          FIFO_AW     = 1;
    localparam logic [3:0]  LAST_BIT_8  = 4'h7;
    localparam logic [3:0]  LAST_BIT_9  = 4'h8;

endpackage : ssr_pkg

/* File: hw/ssr_fifo_mem.sv */
// Small character store with registered read data
module ssr_fifo_mem
    import ssr_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Write side
    input  wire logic                  we,
    input  wire logic [FIFO_AW-1:0]    waddr,
    input  wire logic [WORD_W-1:0]     wdata,
    // Read side
    input  wire logic [FIFO_AW-1:0]    raddr,
    output logic      [WORD_W-1:0]     rdata
);

    // ========================================================
    // Storage array, no reset needed since pointers guard it
    logic [WORD_W-1:0] mem_r [FIFO_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    // Read port is registered, so new data show one cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (we && (waddr == raddr)) begin
            // Write into the slot being read passes straight through, so a
            // word pushed into an empty store is readable the very next cycle
            rdata <= wdata;
        end else begin
            rdata <= mem_r[raddr];
        end
    end

endmodule : ssr_fifo_mem

/* File: hw/ssr_receiver.sv */
// Synchronous slave receive path with APB registers and interrupt
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module ssr_receiver
    import ssr_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link pins driven by the external master
    input  wire logic        shift_clock_pin,
    input  wire logic        shift_data_pin,
    // Core side
    input  wire logic        core_sleep,
    output logic             irq,
    output logic             wake_req
);

    // ========================================================
    // Address decode used by both write and read paths
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction : is_reg

    // ========================================================
    // Declarations
    logic [7:0]          rx_ctl_r;
    logic [7:0]          tx_ctl_r;
    logic [7:0]          baud_r;
    logic [IS_WIDTH-1:0] int_stat_r;
    logic [IS_WIDTH-1:0] int_mask_r;
    logic                ovr_r;
    logic                ck_s1_r, ck_s2_r, ck_s3_r;
    logic                dt_s1_r, dt_s2_r;
    logic [WORD_W-1:0]   sh_r;
    logic [WORD_W-1:0]   sh_nxt;
    logic [WORD_W-1:0]   word_nxt;
    logic [3:0]          bit_cnt_r;
    logic [FIFO_AW:0]    wr_ptr_r, rd_ptr_r;
    logic [WORD_W-1:0]   head;
    logic                port_en, nine_bit, cont_rx, slave_mode, rx_run;
    logic                link_edge, word_done, fifo_full, fifo_empty;
    logic                push, pop, acc, wr_acc, rd_acc, mapped;
    logic [31:0]         rd_mux;
    logic [7:0]          rx_stat_rd, baud_rd;

    // ========================================================
    // Mode decode
    assign port_en    = rx_ctl_r[RS_PORT_EN];
    assign nine_bit   = rx_ctl_r[RS_NINE_BIT];
    assign cont_rx    = rx_ctl_r[RS_CONT_RX];
    // Slave reception needs sync mode, port on, external clock
    assign slave_mode = port_en & tx_ctl_r[TS_SYNC_MODE] & ~tx_ctl_r[TS_CLK_MASTER];
    // Single-receive bit plays no part; core sleep does not gate it
    assign rx_run     = slave_mode & cont_rx;

    // ========================================================
    // APB handshake terms
    assign acc    = psel & penable & pready;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign mapped = is_reg(paddr, OFF_RX_DATA) | is_reg(paddr, OFF_RX_STAT)
                  | is_reg(paddr, OFF_TX_STAT) | is_reg(paddr, OFF_BAUD)
                  | is_reg(paddr, OFF_INT_STAT) | is_reg(paddr, OFF_INT_MASK);

    // ========================================================
    // Link pin synchronisers; only second stage onward is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_s1_r <= 1'h0;
            ck_s2_r <= 1'h0;
            ck_s3_r <= 1'h0;
            dt_s1_r <= 1'h0;
            dt_s2_r <= 1'h0;
        end else begin
            ck_s1_r <= shift_clock_pin;
            ck_s2_r <= ck_s1_r;
            ck_s3_r <= ck_s2_r;
            dt_s1_r <= shift_data_pin;
            dt_s2_r <= dt_s1_r;
        end
    end

    // Clock polarity picks which edge samples data
    assign link_edge = baud_r[BC_CLK_POL] ? (ck_s3_r & ~ck_s2_r) : (~ck_s3_r & ck_s2_r);

    // ========================================================
    // Shift path: LSB first, so each new bit enters at the top
    assign sh_nxt    = {dt_s2_r, sh_r[WORD_W-1:1]};
    // Eight-bit words end one place higher, so realign them down
    assign word_nxt  = nine_bit ? sh_nxt : {1'h0, sh_nxt[WORD_W-1:1]};
    assign word_done = rx_run & link_edge
                     & (bit_cnt_r == (nine_bit ? LAST_BIT_9 : LAST_BIT_8));

    // Shift register and bit counter, cleared while not receiving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r      <= '0;
            bit_cnt_r <= 4'h0;
        end else if (!rx_run) begin
            sh_r      <= '0;
            bit_cnt_r <= 4'h0;
        end else if (link_edge) begin
            sh_r      <= sh_nxt;
            bit_cnt_r <= word_done ? 4'h0 : bit_cnt_r + 4'h1;
        end
    end

    // ========================================================
    // Receive store pointers
    assign fifo_empty = (wr_ptr_r == rd_ptr_r);
    assign fifo_full  = (wr_ptr_r[FIFO_AW] != rd_ptr_r[FIFO_AW])
                      & (wr_ptr_r[FIFO_AW-1:0] == rd_ptr_r[FIFO_AW-1:0]);
    assign push       = word_done & ~fifo_full;
    assign pop        = rd_acc & is_reg(paddr, OFF_RX_DATA) & ~fifo_empty;

    // Dropping the port enable flushes the store as part of port reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (!port_en) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
        end
    end

    ssr_fifo_mem u_mem (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (push),
        .waddr (wr_ptr_r[FIFO_AW-1:0]),
        .wdata (word_nxt),
        .raddr (rd_ptr_r[FIFO_AW-1:0]),
        .rdata (head)
    );

    // ========================================================
    // Overrun: a word that finds the store full is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_r <= 1'h0;
        end else if (!port_en || !cont_rx) begin
            ovr_r <= 1'h0;
        end else if (word_done && fifo_full) begin
            ovr_r <= 1'h1;
        end
    end

    // ========================================================
    // Control registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ctl_r   <= RST_RX_CTL;
            tx_ctl_r   <= RST_TX_CTL;
            baud_r     <= RST_BAUD;
            int_mask_r <= RST_INT;
        end else if (wr_acc) begin
            if (is_reg(paddr, OFF_RX_STAT)) begin
                rx_ctl_r <= {pwdata[7:3], 3'h0};
            end
            if (is_reg(paddr, OFF_TX_STAT)) begin
                tx_ctl_r <= pwdata[7:0];
            end
            if (is_reg(paddr, OFF_BAUD)) begin
                baud_r <= pwdata[7:0];
            end
            if (is_reg(paddr, OFF_INT_MASK)) begin
                int_mask_r <= pwdata[IS_WIDTH-1:0];
            end
        end
    end

    // ========================================================
    // Sticky event bits, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= RST_INT;
        end else begin
            if (wr_acc && is_reg(paddr, OFF_INT_STAT)) begin
                int_stat_r <= int_stat_r & ~pwdata[IS_WIDTH-1:0];
            end
            if (push) begin
                int_stat_r[IS_RX_DONE] <= 1'h1;
            end
            if (word_done && fifo_full) begin
                int_stat_r[IS_OVERRUN] <= 1'h1;
            end
        end
    end

    // Interrupt follows unmasked events, wake only while the core sleeps; mask bit 0 enables receive done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq      <= 1'h0;
            wake_req <= 1'h0;
        end else begin
            irq      <= |(int_stat_r & int_mask_r);
            wake_req <= core_sleep & (|(int_stat_r & int_mask_r));
        end
    end

    // ========================================================
    // Read view; the receiver never shows idle while in slave mode
    assign rx_stat_rd = {rx_ctl_r[7:3], 1'h0, ovr_r, head[WORD_W-1] & ~fifo_empty};
    assign baud_rd    = {baud_r[7], ~slave_mode, baud_r[5:0]};

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFF_RX_DATA:  rd_mux = fifo_empty ? 32'h0 : {24'h0, head[7:0]};
            OFF_RX_STAT:  rd_mux = {24'h0, rx_stat_rd};
            OFF_TX_STAT:  rd_mux = {24'h0, tx_ctl_r};
            OFF_BAUD:     rd_mux = {24'h0, baud_rd};
            OFF_INT_STAT: rd_mux = {30'h0, int_stat_r};
            OFF_INT_MASK: rd_mux = {30'h0, int_mask_r};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // ========================================================
    // One wait state: answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'h0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'h0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'h1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end else begin
            pready  <= 1'h0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'h0;
        end
    end

    // ========================================================
    // Checks
    // Link side: shifting, word length, storage and overrun, with the done flag, interrupt and wake
    chk_ovr_on_full: assert property (@(posedge pclk) disable iff (!presetn)
        word_done && fifo_full |=> ovr_r && (wr_ptr_r == $past(wr_ptr_r)))
        else $error("word into full store did not flag overrun");

    chk_word_stored: assert property (@(posedge pclk) disable iff (!presetn)
        push && !pop |=> (wr_ptr_r - rd_ptr_r) == $past(wr_ptr_r - rd_ptr_r) + 2'h1)
        else $error("completed word not moved into store");

    chk_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        push |=> int_stat_r[IS_RX_DONE])
        else $error("receive complete flag not set");

    chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        int_stat_r[IS_RX_DONE] && int_mask_r[IS_RX_DONE] |=> irq)
        else $error("unmasked receive event gave no interrupt");

    chk_wake_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        core_sleep && (int_stat_r & int_mask_r) != 2'h0 |=> wake_req)
        else $error("no wake while sleeping with pending event");

    chk_ovr_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !cont_rx |=> !ovr_r)
        else $error("overrun survived continuous receive clear");

    chk_port_reset: assert property (@(posedge pclk) disable iff (!presetn)
        !port_en |=> fifo_empty && !ovr_r && bit_cnt_r == 4'h0)
        else $error("port disable did not reset receiver");

    chk_word_len: assert property (@(posedge pclk) disable iff (!presetn)
        word_done |-> bit_cnt_r == (nine_bit ? 4'h8 : 4'h7))
        else $error("character length wrong");

    chk_shift_in: assert property (@(posedge pclk) disable iff (!presetn)
        rx_run && link_edge && !word_done |=> bit_cnt_r == $past(bit_cnt_r) + 4'h1
            && sh_r[WORD_W-1] == $past(dt_s2_r))
        else $error("data bit not shifted on active edge");

    // Sleep must not stall the bit counter, since the link clock is external
    chk_sleep_rx: assert property (@(posedge pclk) disable iff (!presetn)
        core_sleep && rx_run && link_edge |=> bit_cnt_r != $past(bit_cnt_r))
        else $error("reception stalled during core sleep");

    chk_rx_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !rx_run |=> bit_cnt_r == 4'h0 && sh_r == '0)
        else $error("receiver shifted while not enabled");

    // Register and interrupt side
    chk_never_idle: assert property (@(posedge pclk) disable iff (!presetn)
        slave_mode |-> !baud_rd[BC_RX_IDLE])
        else $error("receiver reports idle in slave mode");

    chk_pop_advance: assert property (@(posedge pclk) disable iff (!presetn)
        pop |=> rd_ptr_r == $past(rd_ptr_r) + 2'h1)
        else $error("read of receive data did not release the oldest word");

    chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held for more than one cycle");

    chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (int_stat_r & int_mask_r) == 2'h0 |=> !irq)
        else $error("interrupt raised with no unmasked event");

    chk_wake_awake: assert property (@(posedge pclk) disable iff (!presetn)
        !core_sleep |=> !wake_req)
        else $error("wake requested while the core is awake");

    cov_word_push:   cover property (@(posedge pclk) disable iff (!presetn) push);
    cov_fall_edge:   cover property (@(posedge pclk) disable iff (!presetn)
        push && baud_r[BC_CLK_POL]);
    cov_overrun:     cover property (@(posedge pclk) disable iff (!presetn)
        word_done && fifo_full);
    cov_nine_bit:    cover property (@(posedge pclk) disable iff (!presetn) push && nine_bit);
    cov_sleep_wake:  cover property (@(posedge pclk) disable iff (!presetn)
        core_sleep && push ##[1:4] wake_req);

endmodule : ssr_receiver

/* File: verification/ssr_link_master.sv */
// Behavioural external synchronous master that clocks characters into the receiver
module ssr_link_master (
    // Bench clock that paces the link
    input  wire logic pclk,
    // Link pins toward the receiver
    output logic      shift_clock_pin,
    output logic      shift_data_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic idle_lvl;

    // Clock parks at its idle level between frames; the master only clocks during a character
    initial begin
        idle_lvl        = 1'b0;
        shift_clock_pin = 1'b0;
        shift_data_pin  = 1'b0;
    end

    // ========================================================
    // Move the idle level; only safe while the receiver is disabled, else it is an edge
    task automatic park(input logic lvl);
        @(posedge pclk);
        idle_lvl = lvl;
        shift_clock_pin <= lvl;
    endtask : park

    // One character, LSB first; data settle half a link period before the active edge
    // Four bench clocks per half period give the 200 ns link period
    task automatic send(input logic [8:0] word, input logic nine);
        @(posedge pclk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            shift_data_pin <= word[i];
            repeat (4) @(posedge pclk);
            shift_clock_pin <= ~idle_lvl;
            repeat (4) @(posedge pclk);
            shift_clock_pin <= idle_lvl;
        end
        // Released line shows the inverse so stale data cannot look valid
        shift_data_pin <= ~word[nine ? 8 : 7];
    endtask : send
endmodule : ssr_link_master

/* File: verification/ssr_receiver_tb.sv */
// Self-checking bench for the synchronous slave serial receiver
module ssr_receiver_tb
    import ssr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        shift_clock_pin;
    logic        shift_data_pin;
    logic        core_sleep;
    logic        irq;
    logic        wake_req;
    int          n_fail;
    int          checked;
    logic [32:0] exp_q[$];
    logic [31:0] lfsr_r;
    logic [7:0]  w[3];

    // Clock at 40 MHz
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    ssr_receiver DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .shift_clock_pin(shift_clock_pin),
        .shift_data_pin(shift_data_pin), .core_sleep(core_sleep), .irq(irq),
        .wake_req(wake_req)
    );

    ssr_link_master link (
        .pclk(pclk),
        .shift_clock_pin(shift_clock_pin),
        .shift_data_pin(shift_data_pin)
    );

    // ========================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'hA3000000) : (x >> 1);
    endfunction : lfsr_next

    task automatic note_fail(input string msg);
        n_fail++;
        $display("ERROR %0t %s", $time, msg);
    endtask : note_fail

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // One APB transfer; an idle edge first keeps strobes from being set twice at one edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e, input logic err);
        exp_q.push_back({err, e});
        apb(1'b0, a, 32'h00000000);
    endtask : rd_exp

    task automatic chk(input logic v, input logic e);
        checked++;
        if (v !== e) note_fail("level mismatch on irq or wake");
    endtask : chk

    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        chk(irq, 1'b1);
    endtask : wait_irq

    task automatic send_rand(input logic nine, output logic [7:0] b);
        lfsr_r = lfsr_next(lfsr_r);
        b = lfsr_r[7:0];
        link.send({nine, b}, nine);
    endtask : send_rand

    // ========================================================
    // Read monitor: each completed read takes the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            checked++;
            if (exp_q.size() == 0) begin
                note_fail("read with no expectation");
            end else if ({pslverr, prdata} !== exp_q.pop_front()) begin
                note_fail("read data or error mismatch");
            end
        end
    end

    // Watchdog sized well above the expected run of about 20 us
    initial begin
        #2000000;
        note_fail("timeout");
        tally_and_finish();
    end

    // ========================================================
    // Main sequence
    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h00000000;
        core_sleep = 1'b0;
        n_fail     = 0;
        checked    = 0;
        lfsr_r     = 32'h70FEC750;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values; idle reads set outside slave mode
        rd_exp(OFF_RX_STAT, 32'h00000000, 1'b0);
        rd_exp(OFF_TX_STAT, 32'h00000000, 1'b0);
        rd_exp(OFF_BAUD, 32'h00000040, 1'b0);
        rd_exp(OFF_INT_MASK, 32'h00000000, 1'b0);
        rd_exp(8'h18, 32'h00000000, 1'b1);
        // Slave set-up with single receive also set
        apb(1'b1, OFF_TX_STAT, 32'h00000010);
        apb(1'b1, OFF_INT_MASK, 32'h00000001);
        apb(1'b1, OFF_RX_STAT, 32'h000000B0);
        rd_exp(OFF_BAUD, 32'h00000000, 1'b0);
        rd_exp(OFF_RX_STAT, 32'h000000B0, 1'b0);
        // Eight-bit character while the core sleeps
        core_sleep <= 1'b1;
        send_rand(1'b0, w[0]);
        wait_irq();
        chk(wake_req, 1'b1);
        core_sleep <= 1'b0;
        rd_exp(OFF_INT_STAT, 32'h00000001, 1'b0);
        rd_exp(OFF_RX_DATA, {24'h000000, w[0]}, 1'b0);
        apb(1'b1, OFF_INT_STAT, 32'h00000001);
        rd_exp(OFF_INT_STAT, 32'h00000000, 1'b0);
        chk(irq, 1'b0);
        // Nine-bit character with the top bit set
        apb(1'b1, OFF_RX_STAT, 32'h000000D0);
        send_rand(1'b1, w[0]);
        wait_irq();
        chk(wake_req, 1'b0);
        rd_exp(OFF_RX_STAT, 32'h000000D1, 1'b0);
        rd_exp(OFF_RX_DATA, {24'h000000, w[0]}, 1'b0);
        rd_exp(OFF_RX_STAT, 32'h000000D0, 1'b0);
        // Three characters into a two-deep store, interrupt masked
        apb(1'b1, OFF_INT_STAT, 32'h00000003);
        apb(1'b1, OFF_INT_MASK, 32'h00000000);
        apb(1'b1, OFF_RX_STAT, 32'h00000090);
        for (int i = 0; i < 3; i++) send_rand(1'b0, w[i]);
        repeat (8) @(posedge pclk);
        chk(irq, 1'b0);
        rd_exp(OFF_INT_STAT, 32'h00000003, 1'b0);
        rd_exp(OFF_RX_STAT, 32'h00000092, 1'b0);
        apb(1'b1, OFF_RX_STAT, 32'h00000080);
        rd_exp(OFF_RX_STAT, 32'h00000080, 1'b0);
        rd_exp(OFF_RX_DATA, {24'h000000, w[0]}, 1'b0);
        // Overrun again, then port disable flushes the store and the overrun flag
        apb(1'b1, OFF_RX_STAT, 32'h00000090);
        for (int i = 0; i < 2; i++) send_rand(1'b0, w[i]);
        repeat (8) @(posedge pclk);
        rd_exp(OFF_RX_STAT, 32'h00000092, 1'b0);
        apb(1'b1, OFF_RX_STAT, 32'h00000010);
        rd_exp(OFF_RX_STAT, 32'h00000010, 1'b0);
        rd_exp(OFF_RX_DATA, 32'h00000000, 1'b0);
        // Edges are ignored while the port is off
        apb(1'b1, OFF_INT_STAT, 32'h00000003);
        send_rand(1'b0, w[0]);
        repeat (8) @(posedge pclk);
        rd_exp(OFF_INT_STAT, 32'h00000000, 1'b0);
        // Falling-edge sampling: clock idles high, moved only while the port is off
        apb(1'b1, OFF_BAUD, 32'h00000010);
        link.park(1'b1);
        apb(1'b1, OFF_RX_STAT, 32'h00000090);
        send_rand(1'b0, w[0]);
        repeat (8) @(posedge pclk);
        rd_exp(OFF_BAUD, 32'h00000010, 1'b0);
        rd_exp(OFF_INT_STAT, 32'h00000001, 1'b0);
        rd_exp(OFF_RX_DATA, {24'h000000, w[0]}, 1'b0);
        repeat (4) @(posedge pclk);
        tally_and_finish();
    end
endmodule : ssr_receiver_tb
